// file: hw/emu_fetch_port.sv
// Dedicated fetch port for microcode emulation
`timescale 1ns/1ns
`default_nettype none
module emu_fetch_port
  import sram_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic emu_active,
  input wire logic fetch_req,
  input wire logic [10:0] fetch_addr,
  input wire logic [15:0] mem_q,
  output mem_port_type mem_port,
  output logic [15:0] fetch_data,
  output logic fetch_valid
);

  logic read_pend;

  always_comb begin
    mem_port = '0;
    mem_port.en = emu_active && fetch_req;
    mem_port.addr = fetch_addr;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      read_pend <= 1'b0;
      fetch_valid <= 1'b0;
    end else begin
      read_pend <= emu_active && fetch_req;
      fetch_valid <= read_pend && emu_active;
    end
  end

  always_ff @(posedge mclk) begin
    if (read_pend) begin
      fetch_data <= mem_q;
    end
  end

endmodule // emu_fetch_port
`default_nettype wire

// file: hw/sram_array.sv
// Word-wide static array with byte lanes and registered read data
`timescale 1ns/1ns
`default_nettype none
module sram_array
  import sram_pkg::*;
#(
  parameter int WORDS = 1792
) (
  input wire logic mclk,
  input wire mem_port_type port,
  output logic [15:0] rdata
);

  logic [15:0] mem [WORDS];

  always_ff @(posedge mclk) begin
    if (port.en && port.we) begin
      if (port.be[1]) begin
        mem[port.addr][15:8] <= port.wdata[15:8];
      end
      if (port.be[0]) begin
        mem[port.addr][7:0] <= port.wdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (port.en && !port.we) begin
      rdata <= mem[port.addr];
    end
  end

endmodule // sram_array
`default_nettype wire

// file: hw/sram_params.svh
// Constants for the standby RAM controller
`ifndef SRAM_PARAMS_SVH
`define SRAM_PARAMS_SVH

`define SRAM_CTRL_BASE_LOW 24'h7ffb00
`define SRAM_CTRL_BASE_HIGH 24'hfffb00
`define SRAM_OFF_MCR 3'h0
`define SRAM_OFF_TST 3'h2
`define SRAM_OFF_BAR 3'h4
`define SRAM_MCR_STOP_BIT 15
`define SRAM_MCR_PRIV_BIT 8
`define SRAM_BAR_DS_BIT 0
`define SRAM_RST_STOP 1'b1
`define SRAM_RST_SUP_ONLY 1'b1
`define SRAM_RST_BASE 12'h000
`define SRAM_RST_DS 1'b1
`define SRAM_ARRAY_BYTES 12'he00
`define SRAM_ARRAY_WORDS 1792
`define SRAM_FC_SUP_DATA 3'h5
`define SRAM_FC_DATA 2'h1
`define SRAM_FC_PROG 2'h2
`define SRAM_SIZE_LONG 2'h0
`define SRAM_SIZE_BYTE 2'h1

`endif

// file: hw/sram_pkg.sv
// Types shared by the standby RAM controller files
package sram_pkg;

  typedef enum logic [2:0] {
    idle_st,
    word_st,
    long_a_st,
    long_b_st,
    long_c_st
  } access_state_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic [2:0] fc;
    logic read;
  } bus_cmd_type;

  typedef struct packed {
    logic en;
    logic we;
    logic [10:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } mem_port_type;

endpackage

// file: hw/standby_ram_ctrl.sv
// Standby RAM controller: decoding, control registers, access sequencing
//
// Notes on behaviour
// - 3.5K array in low part of 4K region
// - Array answers program and data space
// - Byte/word two clocks, long two bus cycles
// - Control registers only in supervisor data space
// - Register block at one of two bases
// - Eight-byte block, holes read zero
// - Base bits match address bits 23 to 12
// - Low base bit is disable, set by reset
// - Non-overlapping base write enables the array
// - Base register takes first write only
// - Half write locks the other half too
// - Supervisor-only ignores user array accesses
// - Time processor isolated outside emulation
// - No array access on standby supply; emulation fetches still read the array
// - Stop bit halts array accesses, keeps contents; emulation fetches run regardless of stop
// - Stop bit changes only in supervisor writes
// - Reset sets stop, privilege, disable; clears lock
// - Reset waits for byte/word access end
// - Reset in long access: split by half
// - Emulation serves array over dedicated port
// - Emulation ignores module bus and registers
`timescale 1ns/1ns
`default_nettype none
`include "sram_params.svh"
module standby_ram_ctrl
  import sram_pkg::*;
#(
  parameter int ARRAY_WORDS = `SRAM_ARRAY_WORDS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_req,
  input wire bus_cmd_type bus_cmd,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  input wire logic module_map_select,
  input wire logic standby_supply_pin,
  input wire logic emulation_select,
  input wire logic tp_fetch_req,
  input wire logic [10:0] tp_fetch_addr,
  output logic [15:0] tp_fetch_data,
  output logic tp_fetch_valid
);

  access_state_type state;
  bus_cmd_type lat_cmd;
  bus_cmd_type cur_cmd;
  mem_port_type imb_port;
  mem_port_type emu_port;
  mem_port_type mem_port;
  logic [15:0] mem_q;
  logic [15:0] reg_q;
  logic [15:0] hi_hold;
  logic [15:0] word_q;
  logic [15:0] cur_wd;
  logic [10:0] cur_word_addr;
  logic [1:0] cur_be;
  logic [11:0] base;
  logic [11:0] new_base;
  logic [15:0] base_word;
  logic [23:0] ctrl_base;
  logic stop;
  logic sup_only;
  logic ds;
  logic bar_locked;
  logic lat_reg;
  logic cur_reg;
  logic cur_second;
  logic cur_go;
  logic reg_wr;
  logic hit_reg;
  logic hit_arr;
  logic start;
  logic rst_pend;
  logic rst_req;
  logic apply_rst;
  logic standby_meta;
  logic on_standby;

  // Byte lanes of one 16-bit bus cycle
  function automatic logic [1:0] lanes(input logic [1:0] size, input logic a0);
    if (size == `SRAM_SIZE_BYTE) begin
      lanes = a0 ? 2'b01 : 2'b10;
    end else begin
      lanes = 2'b11;
    end
  endfunction

  // Merge enabled bytes into an old word
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Read view of the control block
  function automatic logic [15:0] reg_word(input logic [2:0] off, input logic st, input logic so,
                                           input logic [11:0] b, input logic d);
    reg_word = 16'h0000;
    if (off == `SRAM_OFF_MCR) begin
      reg_word[`SRAM_MCR_STOP_BIT] = st;
      reg_word[`SRAM_MCR_PRIV_BIT] = so;
    end else if (off == `SRAM_OFF_BAR) begin
      reg_word = {b, 3'h0, d};
    end
  endfunction

  // Standby indication comes from the supply switch, outside the clock
  always_ff @(posedge mclk) begin
    standby_meta <= standby_supply_pin;
    on_standby <= standby_meta;
  end

  always_comb begin
    ctrl_base = module_map_select ? `SRAM_CTRL_BASE_HIGH : `SRAM_CTRL_BASE_LOW;
    hit_reg = !emulation_select
      && bus_cmd.fc == `SRAM_FC_SUP_DATA
      && bus_cmd.addr[23:3] == ctrl_base[23:3];
    hit_arr = !emulation_select
      && !ds && !stop
      && !on_standby
      && bus_cmd.addr[23:12] == base
      && bus_cmd.addr[11:0] < `SRAM_ARRAY_BYTES
      && (bus_cmd.fc[1:0] == `SRAM_FC_DATA || bus_cmd.fc[1:0] == `SRAM_FC_PROG)
      && (!sup_only || bus_cmd.fc[2]);
  end

  // Reset is held off while part of an access still has to finish
  assign rst_req = reset || rst_pend;

  always_comb begin
    unique case (state)
      idle_st: apply_rst = rst_req;
      word_st: apply_rst = rst_req;
      long_a_st: apply_rst = rst_req;
      long_b_st: apply_rst = 1'b0;
      long_c_st: apply_rst = rst_req;
      default: apply_rst = rst_req;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (apply_rst) begin
      rst_pend <= 1'b0;
    end else if (reset) begin
      rst_pend <= 1'b1;
    end
  end

  assign start = bus_req && state == idle_st && !apply_rst && (hit_reg || hit_arr);

  // Current bus cycle: the first half comes live, the second from the latch
  always_comb begin
    cur_second = state == long_b_st;
    cur_go = start || cur_second;
    cur_cmd = cur_second ? lat_cmd : bus_cmd;
    cur_reg = cur_second ? lat_reg : hit_reg;
    cur_word_addr = cur_second ? lat_cmd.addr[11:1] + 11'h001 : bus_cmd.addr[11:1];
    cur_be = cur_second ? 2'b11 : lanes(bus_cmd.size, bus_cmd.addr[0]);
    if (cur_second) begin
      cur_wd = lat_cmd.wdata[15:0];
    end else if (bus_cmd.size == `SRAM_SIZE_LONG) begin
      cur_wd = bus_cmd.wdata[31:16];
    end else if (bus_cmd.size == `SRAM_SIZE_BYTE) begin
      cur_wd = {bus_cmd.wdata[7:0], bus_cmd.wdata[7:0]};
    end else begin
      cur_wd = bus_cmd.wdata[15:0];
    end
    reg_wr = cur_go && cur_reg && !cur_cmd.read;
    base_word = merge({base, 4'h0}, cur_wd, cur_be);
    new_base = base_word[15:4];
  end

  always_comb begin
    imb_port.en = cur_go && !cur_reg;
    imb_port.we = !cur_cmd.read;
    imb_port.addr = cur_word_addr;
    imb_port.be = cur_be;
    imb_port.wdata = cur_wd;
    mem_port = emulation_select ? emu_port : imb_port;
  end

  // Access sequencer
  always_ff @(posedge mclk) begin
    if (apply_rst) begin
      state <= idle_st;
    end else begin
      unique case (state)
        idle_st: begin
          if (start) begin
            state <= bus_cmd.size == `SRAM_SIZE_LONG ? long_a_st : word_st;
          end
        end
        word_st: state <= idle_st;
        long_a_st: state <= long_b_st;
        long_b_st: state <= long_c_st;
        long_c_st: state <= idle_st;
        default: state <= idle_st;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (start) begin
      lat_cmd <= bus_cmd;
      lat_reg <= hit_reg;
    end
  end

  // Register read data for the current bus cycle
  always_ff @(posedge mclk) begin
    if (cur_go) begin
      reg_q <= reg_word({cur_word_addr[1:0], 1'b0}, stop, sup_only, base, ds);
    end
  end

  assign word_q = lat_reg ? reg_q : mem_q;

  always_ff @(posedge mclk) begin
    if (start) begin
      hi_hold <= 16'h0000;
    end else if (state == long_a_st) begin
      hi_hold <= word_q;
    end
  end

  assign bus_ack = state == word_st || state == long_c_st || (state == long_a_st && rst_req);
  assign bus_rdata = state == long_c_st ? {hi_hold, word_q} : {16'h0000, word_q};

  // Module configuration: stop and privilege
  always_ff @(posedge mclk) begin
    if (apply_rst) begin
      stop <= `SRAM_RST_STOP;
      sup_only <= `SRAM_RST_SUP_ONLY;
    end else if (reg_wr && {cur_word_addr[1:0], 1'b0} == `SRAM_OFF_MCR && cur_be[1]) begin
      if (cur_cmd.fc[2]) begin
        stop <= cur_wd[`SRAM_MCR_STOP_BIT];
      end
      sup_only <= cur_wd[`SRAM_MCR_PRIV_BIT];
    end
  end

  // Base address, disable flag and write-once lock
  always_ff @(posedge mclk) begin
    if (apply_rst) begin
      base <= `SRAM_RST_BASE;
      ds <= `SRAM_RST_DS;
      bar_locked <= 1'b0;
    end else if (reg_wr && {cur_word_addr[1:0], 1'b0} == `SRAM_OFF_BAR && !bar_locked) begin
      base <= new_base;
      ds <= new_base == ctrl_base[23:12];
      bar_locked <= 1'b1;
    end
  end

  sram_array #(
    .WORDS(ARRAY_WORDS)
  ) u_array (
    .mclk(mclk),
    .port(mem_port),
    .rdata(mem_q)
  );

  emu_fetch_port u_emu (
    .mclk(mclk),
    .reset(reset),
    .emu_active(emulation_select),
    .fetch_req(tp_fetch_req),
    .fetch_addr(tp_fetch_addr),
    .mem_q(mem_q),
    .mem_port(emu_port),
    .fetch_data(tp_fetch_data),
    .fetch_valid(tp_fetch_valid)
  );

endmodule // standby_ram_ctrl
`default_nettype wire

// file: tb/standby_ram_ctrl_props.sv
// Checker of bus and fetch timing for the standby RAM controller
`timescale 1ns/1ns
`default_nettype none
`include "sram_params.svh"
module standby_ram_ctrl_props
  import sram_pkg::*;
#(
  parameter int ARRAY_WORDS = 1792
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_req,
  input wire bus_cmd_type bus_cmd,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic module_map_select,
  input wire logic standby_supply_pin,
  input wire logic emulation_select,
  input wire logic tp_fetch_req,
  input wire logic [10:0] tp_fetch_addr,
  input wire logic [15:0] tp_fetch_data,
  input wire logic tp_fetch_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [23:0] reg_base;
  assign reg_base = module_map_select ? `SRAM_CTRL_BASE_HIGH : `SRAM_CTRL_BASE_LOW;
  sequence fresh_s;
    bus_req && !$past(bus_req) && !$past(reset) && !emulation_select && !$past(emulation_select);
  endsequence
  sequence reg_word_s;
    fresh_s ##0 (bus_cmd.fc == 3'h5 && bus_cmd.addr[23:3] == reg_base[23:3] && bus_cmd.size != 2'h0);
  endsequence
  AST_REG_ACK: assert property (reg_word_s |=> bus_ack) else $error("register access not acknowledged");
  AST_HOLE_ZERO: assert property (
    reg_word_s ##0 (bus_cmd.read && bus_cmd.addr[2:0] == 3'h2) |=> bus_rdata == 32'h0)
    else $error("unused register not zero");
  AST_REG_SUP: assert property (
    bus_req && bus_cmd.fc != 3'h5 && bus_cmd.addr[23:3] == reg_base[23:3] |=> !bus_ack)
    else $error("register answered outside supervisor data");
  AST_ACK_CAUSE: assert property (bus_ack |-> $past(bus_req)) else $error("ack without request");
  AST_ACK_PULSE: assert property (bus_ack |=> !bus_ack) else $error("ack longer than one cycle");
  AST_EMU_QUIET: assert property (emulation_select && $past(emulation_select) |-> !bus_ack)
    else $error("bus answered in emulation");
  AST_FETCH_LAT: assert property (emulation_select && tp_fetch_req |=> ##1 tp_fetch_valid)
    else $error("fetch not answered in two cycles");
  AST_FETCH_NONE: assert property (!(emulation_select && tp_fetch_req) |=> ##1 !tp_fetch_valid)
    else $error("fetch answer without request");
endmodule // standby_ram_ctrl_props
bind standby_ram_ctrl standby_ram_ctrl_props #(.ARRAY_WORDS(ARRAY_WORDS)) i_props (.mclk(mclk), .reset(reset),
  .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
  .module_map_select(module_map_select), .standby_supply_pin(standby_supply_pin),
  .emulation_select(emulation_select), .tp_fetch_req(tp_fetch_req), .tp_fetch_addr(tp_fetch_addr),
  .tp_fetch_data(tp_fetch_data), .tp_fetch_valid(tp_fetch_valid));
`default_nettype wire

// file: tb/tb.sv
// Testbench of the standby RAM controller
`timescale 1ns/1ns
`default_nettype none
`include "sram_params.svh"
module tb;
  import sram_pkg::*;
  localparam logic [23:0] RB = `SRAM_CTRL_BASE_LOW;
  localparam logic [23:0] AB = 24'h012000;
  logic mclk, reset, bus_req, bus_ack, mms, stby, emu, req, tpv, go, got;
  bus_cmd_type bus_cmd;
  logic [31:0] bus_rdata, rd;
  logic [10:0] tpa;
  logic [15:0] tpd;
  logic [15:0] exp_fetch [2] = '{16'h1234, 16'habcd};
  int err_total = 0, checked = 0, nf = 0, cycles = 0;
  standby_ram_ctrl i_standby_ram_ctrl (.mclk(mclk), .reset(reset), .bus_req(bus_req), .bus_cmd(bus_cmd),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .module_map_select(mms), .standby_supply_pin(stby),
    .emulation_select(emu), .tp_fetch_req(req), .tp_fetch_addr(tpa), .tp_fetch_data(tpd), .tp_fetch_valid(tpv));
  tp_model i_tp_model (.mclk(mclk), .reset(reset), .go(go), .emu(emu), .req(req), .addr(tpa));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_ack(input logic e);
    chk({31'h0, got}, {31'h0, e});
  endtask
  task automatic acc(input logic r, input logic [1:0] sz, input logic [2:0] fc, input logic [23:0] a,
    input logic [31:0] wd);
    int n;
    @(negedge mclk);
    bus_cmd = '{addr: a, wdata: wd, size: sz, fc: fc, read: r};
    bus_req = 1'b1;
    got = 1'b0;
    for (n = 0; n < 6 && !got; n++) begin
      @(negedge mclk);
      if (bus_ack === 1'b1) begin
        got = 1'b1;
        rd = bus_rdata;
      end
    end
    @(negedge mclk);
    bus_req = 1'b0;
    bus_cmd.addr = ~a;
  endtask
  task automatic do_reset;
    @(negedge mclk);
    reset = 1'b1;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (tpv === 1'b1 && nf < 2) begin
      chk({16'h0, tpd}, {16'h0, exp_fetch[nf]});
      nf++;
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    reset = 1'b1;
    bus_req = 1'b0;
    bus_cmd = '0;
    mms = 1'b0;
    stby = 1'b0;
    go = 1'b0;
    got = 1'b0;
    rd = 32'h0;
    do_reset;
    acc(1, 2'h2, 3'h5, RB, 0); chk(rd, 32'h8100);
    acc(1, 2'h2, 3'h5, RB + 4, 0); chk(rd, 32'h0001);
    acc(1, 2'h2, 3'h5, RB + 2, 0); chk(rd, 32'h0);
    acc(1, 2'h2, 3'h1, RB, 0); chk_ack(0);
    acc(0, 2'h2, 3'h5, RB + 4, 32'h7ff0); acc(1, 2'h2, 3'h5, RB + 4, 0); chk(rd, 32'h7ff1);
    acc(0, 2'h2, 3'h5, RB + 4, 32'h0120); acc(1, 2'h2, 3'h5, RB + 4, 0); chk(rd, 32'h7ff1);
    do_reset;
    acc(0, 2'h1, 3'h5, RB + 4, 32'h01); acc(0, 2'h2, 3'h5, RB + 4, 32'h0120);
    acc(1, 2'h2, 3'h5, RB + 4, 0); chk(rd, 32'h0100);
    do_reset;
    acc(0, 2'h2, 3'h5, RB + 4, 32'h0120); acc(1, 2'h2, 3'h5, RB + 4, 0); chk(rd, 32'h0120);
    acc(1, 2'h2, 3'h5, AB, 0); chk_ack(0);
    acc(0, 2'h2, 3'h5, RB, 32'h0100);
    acc(1, 2'h2, 3'h1, AB, 0); chk_ack(0);
    acc(0, 2'h0, 3'h5, AB, 32'h1234abcd); acc(1, 2'h0, 3'h5, AB, 0); chk(rd, 32'h1234abcd);
    acc(1, 2'h1, 3'h5, AB + 1, 0); chk(rd, 32'h1234);
    acc(1, 2'h2, 3'h6, AB + 2, 0); chk(rd, 32'habcd);
    acc(1, 2'h2, 3'h5, AB + 24'he00, 0); chk_ack(0);
    acc(0, 2'h2, 3'h5, RB, 32'h0); acc(1, 2'h2, 3'h1, AB, 0); chk(rd, 32'h1234);
    stby = 1'b1;
    repeat (3) @(negedge mclk);
    acc(1, 2'h2, 3'h5, AB, 0); chk_ack(0);
    stby = 1'b0;
    go = 1'b1;
    repeat (6) @(negedge mclk);
    acc(1, 2'h2, 3'h5, AB, 0); chk_ack(0);
    chk(nf, 2);
    give_verdict;
  end
endmodule // tb
`default_nettype wire

// file: tb/tp_model.sv
// Time processor model: selects emulation once, then fetches words in order
`timescale 1ns/1ns
`default_nettype none
module tp_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic go,
  output logic emu,
  output logic req,
  output logic [10:0] addr
);
  initial begin
    emu = 1'b0;
    req = 1'b0;
    addr = 11'h0;
  end
  always @(posedge mclk) begin
    if (reset) emu <= 1'b0;
    else if (go) emu <= 1'b1;
    // Requests run before emulation too, which the block must ignore
    req <= !reset;
    if (!emu) addr <= go ? 11'h0 : ~addr;
    else addr <= addr + 11'h1;
  end
endmodule // tp_model
`default_nettype wire
